/* design/fuse_lock_map.vh */
// constants for the self-programming control block
`ifndef FUSE_LOCK_MAP_VH
`define FUSE_LOCK_MAP_VH
// apb byte offsets
`define FLR_CTRL_ADDR 12'h000
`define FLR_PTR_ADDR 12'h004
`define FLR_INSN_ADDR 12'h008
`define FLR_DATA_ADDR 12'h00c
`define FLR_FUSE_ADDR 12'h010
// control register field positions
`define FLR_BIT_ENABLE 0
`define FLR_BIT_ERASE 1
`define FLR_BIT_WRITE 2
`define FLR_BIT_READSEL 3
`define FLR_BIT_REENABLE 4
`define FLR_BIT_BUSY 6
// accepted low five bit combinations
`define FLR_CMD_REENABLE 5'h11
`define FLR_CMD_READSEL 5'h09
`define FLR_CMD_WRITE 5'h05
`define FLR_CMD_ERASE 5'h03
`define FLR_CMD_LOAD 5'h01
// instruction codes written to the instruction register
`define FLR_INSN_LOAD 2'h1
`define FLR_INSN_STORE 2'h2
// pointer values selecting each byte
`define FLR_SEL_FUSE_LOW 2'h0
`define FLR_SEL_LOCK 2'h1
`define FLR_SEL_EXT_FUSE 2'h2
`define FLR_SEL_FUSE_HIGH 2'h3
// window lengths in cpu cycles
`define FLR_LOAD_WINDOW 3'h3
`define FLR_STORE_WINDOW 3'h4
// reset values
`define FLR_CTRL_RESET 8'h00
`define FLR_PTR_RESET 16'h0000
`endif

/* design/flr_rc_timer.v */
// programming duration timer counting rc oscillator ticks
`timescale 1ns/10ps
module flr_rc_timer #(
  parameter integer TICKS = 512
) (
  input wire clk_sys,
  input wire rst_b,
  input wire start,
  input wire rcTick,
  output wire busy,
  output reg done
);
  reg [31:0] count_reg;
  reg run_reg;
  assign busy = run_reg;
  // load on start, count rc ticks down, pulse done at zero
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      count_reg <= 32'h0;
      run_reg <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !run_reg) begin
        count_reg <= TICKS;
        run_reg <= 1'b1;
      end else if (run_reg && rcTick) begin
        if (count_reg <= 32'h1) begin
          run_reg <= 1'b0;
          done <= 1'b1;
          count_reg <= 32'h0;
        end else begin
          count_reg <= count_reg - 32'h1;
        end
      end
    end
  end
endmodule // flr_rc_timer

/* design/flr_self_prog.v */
// self-programming control with fuse and lock readout window
//
// Functional notes
// - pointer 1 plus armed window, load within three cycles returns lock byte
// - enable and select clear on readout, load timeout, or store timeout
// - with window disarmed the load returns the ordinary flash byte
// - pointer 0 with armed window returns fuse low byte
// - pointer 3 with armed window returns fuse high byte
// - pointer 2 with armed window returns extended fuse byte
// - programmed bits read zero, unprogrammed bits read one
// - a write in progress finishes across a reset while supplyOk is high
// - erase and write last 3.7 to 4.5 ms of rc time
// - concurrent section busy flag always reads zero
// - only five low bit combinations are accepted, others ignored
// - eeprom write blocks flash programming and fuse readout
// - cpu stalls for the whole erase or write
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "fuse_lock_map.vh"
module flr_self_prog #(
  parameter integer RC_HZ = 128000,
  parameter integer PROG_TIME_US = 4100,
  parameter integer PROG_MIN_US = 3700,
  parameter integer PROG_MAX_US = 4500
) (
  input wire clk_sys,
  input wire rst_b,
  input wire rcTick,
  input wire supplyOk,
  input wire eepromWriteBusy,
  input wire [7:0] fuseLowProg,
  input wire [7:0] fuseHighProg,
  input wire [7:0] extFuseProg,
  input wire [7:0] lockProg,
  input wire [7:0] flashByte,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire cpuStall,
  output reg flashErase,
  output reg flashWrite,
  output reg bufferLoad,
  output reg bufferClear,
  output wire [15:0] flashAddr
);
  // rc ticks for the nominal duration; must stay inside min and max
  localparam integer PROG_TICKS = (RC_HZ / 1000) * PROG_TIME_US / 1000;
  localparam integer MIN_TICKS = ((RC_HZ / 1000) * PROG_MIN_US + 999) / 1000;
  localparam integer MAX_TICKS = (RC_HZ / 1000) * PROG_MAX_US / 1000;
  localparam integer RUN_TICKS = (PROG_TICKS < MIN_TICKS) ? MIN_TICKS :
    ((PROG_TICKS > MAX_TICKS) ? MAX_TICKS : PROG_TICKS);
  // operation states, one-hot
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_ARMED = 3'b010;
  localparam [2:0] ST_PROG = 3'b100;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [4:0] ctrl_reg;
  reg [4:0] ctrl_next;
  reg [2:0] window_reg;
  reg [2:0] window_next;
  reg [15:0] ptr_reg;
  reg [7:0] loadData_reg;
  reg [7:0] loadData_next;
  reg progPending_reg;
  wire apbWrite;
  wire apbRead;
  wire insnWrite;
  wire insnLoad;
  wire insnStore;
  wire ctrlWrite;
  wire [4:0] cmd;
  wire cmdOk;
  wire readArmed;
  wire timerBusy;
  wire timerDone;
  reg timerStart;
  reg [7:0] fuseSel;
  wire timerRst_b;

  assign apbWrite = psel && penable && pwrite;
  assign apbRead = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign ctrlWrite = apbWrite && (paddr == `FLR_CTRL_ADDR);
  assign insnWrite = apbWrite && (paddr == `FLR_INSN_ADDR);
  assign insnLoad = insnWrite && (pwdata[1:0] == `FLR_INSN_LOAD);
  assign insnStore = insnWrite && (pwdata[1:0] == `FLR_INSN_STORE);
  assign cmd = pwdata[4:0];
  assign flashAddr = ptr_reg;
  // stall while the timed operation runs, also across a reset that it survives
  assign cpuStall = (state_reg == ST_PROG);
  // the duration timer must keep counting through a reset the run survives,
  // otherwise the held state would wait for a done pulse that never comes
  assign timerRst_b = rst_b || ((state_reg == ST_PROG) && supplyOk);
  assign readArmed = (state_reg == ST_ARMED) && ctrl_reg[`FLR_BIT_READSEL];

  // only the five documented combinations are accepted
  assign cmdOk = (cmd == `FLR_CMD_REENABLE) || (cmd == `FLR_CMD_READSEL) ||
    (cmd == `FLR_CMD_WRITE) || (cmd == `FLR_CMD_ERASE) ||
    (cmd == `FLR_CMD_LOAD);

  flr_rc_timer #(
    .TICKS(RUN_TICKS)
  ) uTimer (
    .clk_sys(clk_sys),
    .rst_b(timerRst_b),
    .start(timerStart),
    .rcTick(rcTick),
    .busy(timerBusy),
    .done(timerDone)
  );

  // fuse or lock byte chosen by the two low pointer bits, inverted
  always @* begin
    case (ptr_reg[1:0])
      `FLR_SEL_FUSE_LOW: fuseSel = ~fuseLowProg;
      `FLR_SEL_LOCK: fuseSel = ~lockProg;
      `FLR_SEL_EXT_FUSE: fuseSel = ~extFuseProg;
      default: fuseSel = ~fuseHighProg;
    endcase
  end

  // control state machine
  always @* begin
    state_next = state_reg;
    ctrl_next = ctrl_reg;
    window_next = window_reg;
    loadData_next = loadData_reg;
    timerStart = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        // eeprom write blocks every command
        if (ctrlWrite && cmdOk && !eepromWriteBusy) begin
          ctrl_next = cmd;
          state_next = ST_ARMED;
          window_next = 3'h0;
        end
        if (insnLoad) begin
          loadData_next = flashByte;
        end
      end
      ST_ARMED: begin
        window_next = window_reg + 3'h1;
        if (insnLoad && readArmed && window_reg < `FLR_LOAD_WINDOW) begin
          loadData_next = fuseSel;
          ctrl_next = 5'h00;
          state_next = ST_IDLE;
        end else if (insnStore && !ctrl_reg[`FLR_BIT_READSEL] &&
            window_reg < `FLR_STORE_WINDOW) begin
          if (ctrl_reg[`FLR_BIT_ERASE] || ctrl_reg[`FLR_BIT_WRITE]) begin
            timerStart = 1'b1;
            state_next = ST_PROG;
          end else begin
            ctrl_next = 5'h00;
            state_next = ST_IDLE;
          end
        end else if ((readArmed && window_reg >= `FLR_LOAD_WINDOW - 3'h1) ||
            (window_reg >= `FLR_STORE_WINDOW - 3'h1)) begin
          ctrl_next = 5'h00;
          state_next = ST_IDLE;
        end else if (insnLoad) begin
          loadData_next = flashByte;
        end
      end
      ST_PROG: begin
        // enable stays up until the rc-timed operation completes
        if (timerDone) begin
          ctrl_next = 5'h00;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
        ctrl_next = 5'h00;
      end
    endcase
  end

  // state registers; a running operation survives reset when supply is good
  always @(posedge clk_sys) begin
    if (!rst_b && !(state_reg == ST_PROG && supplyOk)) begin
      state_reg <= ST_IDLE;
      ctrl_reg <= 5'h00;
      window_reg <= 3'h0;
      loadData_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      ctrl_reg <= ctrl_next;
      window_reg <= window_next;
      loadData_reg <= loadData_next;
    end
  end

  // pointer register
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      ptr_reg <= `FLR_PTR_RESET;
    end else if (apbWrite && paddr == `FLR_PTR_ADDR && !cpuStall) begin
      ptr_reg <= pwdata[15:0];
    end
  end

  // flash strobes: one cycle at the store, buffer clear on re-enable
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      flashErase <= 1'b0;
      flashWrite <= 1'b0;
      bufferLoad <= 1'b0;
      bufferClear <= 1'b0;
      progPending_reg <= 1'b0;
    end else begin
      flashErase <= timerStart && ctrl_reg[`FLR_BIT_ERASE];
      flashWrite <= timerStart && ctrl_reg[`FLR_BIT_WRITE];
      bufferLoad <= (state_reg == ST_ARMED) && insnStore &&
        (ctrl_reg == `FLR_CMD_LOAD) && window_reg < `FLR_STORE_WINDOW;
      bufferClear <= (state_reg == ST_ARMED) && insnStore &&
        ctrl_reg[`FLR_BIT_REENABLE] && window_reg < `FLR_STORE_WINDOW;
      progPending_reg <= timerBusy;
    end
  end

  // apb read data, unmapped reads as zero
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == `FLR_CTRL_ADDR) begin
        // busy flag bit 6 is held at zero
        prdata <= {24'h0, 1'b0, 1'b0, 1'b0, ctrl_reg};
      end else if (paddr == `FLR_PTR_ADDR) begin
        prdata <= {16'h0, ptr_reg};
      end else if (paddr == `FLR_DATA_ADDR) begin
        prdata <= {24'h0, loadData_reg};
      end else if (paddr == `FLR_FUSE_ADDR) begin
        prdata <= {29'h0, progPending_reg, eepromWriteBusy, state_reg[2]};
      end else begin
        prdata <= 32'h0;
      end
    end
  end
endmodule // flr_self_prog

/* dv/flr_self_prog_chk.sv */
// port checker for the self-programming block
`timescale 1ns/10ps
module flr_self_prog_chk (
  input wire clk_sys,
  input wire rst_b,
  input wire supplyOk,
  input wire eepromWriteBusy,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire cpuStall,
  input wire flashErase
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // control register write, read setup and accepted patterns
  wire ctlWr = psel && penable && pwrite && paddr == 12'h000;
  wire ctlRd = psel && !penable && !pwrite && paddr == 12'h000;
  wire okCmd = pwdata[4:0] inside {5'h11, 5'h09, 5'h05, 5'h03, 5'h01};
  // stall held for a run, and no stall for a while
  sequence sHold;
    cpuStall [*8];
  endsequence
  sequence sIdle;
    !cpuStall [*4];
  endsequence
  AST_STALL_MIN: assert property ($rose(cpuStall) |-> sHold)
    else $error("stall too short");
  AST_STALL_END: assert property ($rose(cpuStall) |-> ##[1:300] !cpuStall)
    else $error("stall never ends");
  AST_ERASE_STALL: assert property (flashErase |-> ##[0:2] cpuStall)
    else $error("erase without stall");
  AST_BUSY_ZERO: assert property (ctlRd |=> !prdata[6])
    else $error("busy flag set");
  AST_EN_HELD: assert property (ctlRd && cpuStall |=> prdata[0])
    else $error("enable dropped in run");
  AST_BAD_CMD: assert property (ctlWr && !okCmd && !cpuStall |=> sIdle)
    else $error("bad pattern acted");
  AST_EE_BLOCK: assert property (ctlWr && eepromWriteBusy && !cpuStall |=> sIdle)
    else $error("eeprom did not block");
  AST_RESET_RUN: assert property (disable iff (1'b0) cpuStall && !rst_b && supplyOk |=> cpuStall)
    else $error("reset aborted run");
endmodule // flr_self_prog_chk
bind flr_self_prog flr_self_prog_chk u_flr_self_prog_chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .supplyOk(supplyOk), .eepromWriteBusy(eepromWriteBusy), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .cpuStall(cpuStall),
  .flashErase(flashErase));

/* dv/flr_flash_model.sv */
// flash array and rc oscillator model
`timescale 1ns/10ps
module flr_flash_model (
  input wire clk_sys,
  input wire [15:0] flashAddr,
  output logic rcTick = 1'b0,
  output wire [7:0] flashByte
);
  logic [1:0] div = 2'h0;
  // rc tick every fourth system clock
  always @(posedge clk_sys) begin
    div <= div + 2'h1;
    rcTick <= (div == 2'h3);
  end
  // stored byte follows its address so reads are distinguishable
  assign flashByte = flashAddr[7:0] ^ 8'h5a;
endmodule // flr_flash_model

/* dv/flr_self_prog_tb_top.sv */
// self-checking bench for the self-programming block
`timescale 1ns/10ps
module flr_self_prog_tb_top;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic supplyOk = 1'b1;
  logic eeBusy = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] fz [4];
  logic [4:0] cmds [7] = '{5'h11, 5'h09, 5'h05, 5'h03, 5'h01, 5'h07, 5'h1f};
  wire [31:0] prdata;
  wire [15:0] flashAddr;
  wire [7:0] flashByte;
  wire rcTick, pready, pslverr, cpuStall, flashErase, flashWrite, bufferLoad, bufferClear;
  integer nErase = 0;
  integer nWrite = 0;
  integer nLoad = 0;
  integer nClear = 0;
  integer stallCyc = 0;
  integer s0;
  logic [63:0] noteQ [$];
  integer seed = 97;
  integer bad_count = 0;
  integer tests_run = 0;
  integer cyc = 0;
  integer n;
  flr_self_prog #(.RC_HZ(1000)) u_flr_self_prog (.clk_sys(clk_sys), .rst_b(rst_b),
    .rcTick(rcTick), .supplyOk(supplyOk), .eepromWriteBusy(eeBusy), .fuseLowProg(fz[0]),
    .fuseHighProg(fz[3]), .extFuseProg(fz[2]), .lockProg(fz[1]), .flashByte(flashByte),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpuStall(cpuStall),
    .flashErase(flashErase), .flashWrite(flashWrite), .bufferLoad(bufferLoad),
    .bufferClear(bufferClear), .flashAddr(flashAddr));
  flr_flash_model u_flr_flash_model (.clk_sys(clk_sys), .flashAddr(flashAddr),
    .rcTick(rcTick), .flashByte(flashByte));
  // system clock
  initial forever #2.5 clk_sys = ~clk_sys;
  // compare one value with its expectation
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; a read with a mask notes its mask and expectation
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] m = 32'h0, input logic [31:0] e = 32'h0);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w && m != 32'h0) noteQ.push_back({m, e});
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    penable <= 1'b0;
  endtask
  // bus released for some cycles
  task automatic idle(input integer k);
    psel <= 1'b0;
    repeat (k) @(posedge clk_sys);
  endtask
  // software step: poll enable clear, wait for eeprom idle, then control write and store
  task automatic spm(input logic [4:0] c, input logic [1:0] op);
    integer t;
    t = 0;
    do begin
      apb(0, 12'h000, 0);
      t++;
    end while (prdata[0] !== 1'b0 && t < 100);
    while (eeBusy) @(posedge clk_sys);
    apb(1, 12'h000, {27'h0, c});
    apb(1, 12'h008, {30'h0, op});
  endtask
  task automatic conclude;
    if (bad_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // read results against the oldest note, and the hang limit
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (psel && penable && !pwrite && pready === 1'b1 && noteQ.size() > 0) begin
      chk(prdata & noteQ[0][63:32], noteQ[0][31:0]);
      chk({31'h0, pslverr}, 32'h0);
      void'(noteQ.pop_front());
    end
    // strobe pulses and stall cycles counted for later checks
    if (flashErase) nErase <= nErase + 1;
    if (flashWrite) nWrite <= nWrite + 1;
    if (bufferLoad) nLoad <= nLoad + 1;
    if (bufferClear) nClear <= nClear + 1;
    if (cpuStall) stallCyc <= stallCyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      conclude();
    end
  end
  // main sequence
  initial begin
    foreach (fz[i]) fz[i] = 8'($random(seed));
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    // every fuse and lock byte, inverted, chosen by the pointer
    for (int i = 0; i < 4; i++) begin
      apb(1, 12'h004, i);
      apb(1, 12'h000, 32'h09);
      apb(1, 12'h008, 32'h1);
      apb(0, 12'h00c, 0, 32'hff, {24'h0, ~fz[i]});
      apb(0, 12'h000, 0, 32'h5f, 32'h0);
    end
    // windows lapse: load reads flash, late store does nothing
    apb(1, 12'h000, 32'h09);
    idle(4);
    apb(1, 12'h008, 32'h1);
    apb(0, 12'h00c, 0, 32'hff, 32'h59);
    apb(1, 12'h000, 32'h03);
    idle(5);
    apb(1, 12'h008, 32'h2);
    apb(0, 12'h000, 0, 32'h5f, 32'h0);
    chk({31'h0, cpuStall}, 32'h0);
    // accepted patterns read back, others are ignored
    foreach (cmds[k]) begin
      apb(1, 12'h000, {27'h0, cmds[k]});
      if (k >= 5) apb(1, 12'h008, 32'h2);
      apb(0, 12'h000, 0, 32'h1f, k < 5 ? {27'h0, cmds[k]} : 32'h0);
      idle(6);
    end
    // erase then write, each hit by a reset in mid-run
    for (int j = 1; j < 3; j++) begin
      s0 = stallCyc;
      apb(1, 12'h000, 32'h1 | (32'h1 << j));
      apb(1, 12'h008, 32'h2);
      apb(0, 12'h000, 0, 32'h41, 32'h1);
      idle(1);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      n = 0;
      while (cpuStall === 1'b1 && n < 400) begin
        @(negedge clk_sys);
        n++;
      end
      @(posedge clk_sys);
      chk({31'h0, cpuStall}, 32'h0);
      chk({31'h0, n > 3}, 32'h1);
      // four rc periods of four clocks; the first period may be partial
      chk({31'h0, (stallCyc - s0) >= 14 && (stallCyc - s0) <= 18}, 32'h1);
      apb(0, 12'h000, 0, 32'h41, 32'h0);
    end
    // page update: erase, re-enable, fill two words, rewind, write, re-enable, verify
    spm(5'h03, 2'h2);
    spm(5'h11, 2'h2);
    for (int w = 0; w < 2; w++) begin
      apb(1, 12'h004, 2 * w);
      spm(5'h01, 2'h2);
    end
    apb(1, 12'h004, 0);
    spm(5'h05, 2'h2);
    do begin
      spm(5'h11, 2'h2);
      apb(0, 12'h000, 0);
    end while (prdata[6] !== 1'b0);
    apb(1, 12'h008, 32'h1);
    apb(0, 12'h00c, 0, 32'hff, 32'h5a);
    chk(nErase, 2);
    chk(nWrite, 2);
    chk(nLoad, 2);
    chk(nClear, 2);
    // eeprom activity blocks the readout, so the load reads flash
    eeBusy <= 1'b1;
    apb(1, 12'h000, 32'h09);
    apb(1, 12'h008, 32'h1);
    apb(0, 12'h00c, 0, 32'hff, 32'h5a);
    eeBusy <= 1'b0;
    apb(0, 12'h020, 0, 32'hffffffff, 32'h0);
    idle(2);
    conclude();
  end
endmodule // flr_self_prog_tb_top
